/* File: inc/src_cfg.svh */
// src_cfg.svh: offsets, byte values and timing counts of the host
// controller for the spi register command link; no logic here.
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH
// ==========================================================
// software register byte offsets
`define SRC_OFS_CMD    8'h00
`define SRC_OFS_CFG    8'h04
`define SRC_OFS_WDLO   8'h08
`define SRC_OFS_WDHI   8'h0c
`define SRC_OFS_RDLO   8'h10
`define SRC_OFS_RDHI   8'h14
`define SRC_OFS_STAT   8'h18
`define SRC_OFS_ELAP   8'h1c
// ==========================================================
// field positions
`define SRC_CMD_GO     31
`define SRC_CMD_OP_HI  15
`define SRC_CMD_OP_LO  14
`define SRC_CMD_LEN_HI 13
`define SRC_CMD_LEN_LO 12
`define SRC_ST_BUSY    0
`define SRC_ST_DONE    1
`define SRC_ST_CRC     2
`define SRC_ST_ECHO    3
`define SRC_ST_SYNC    4
`define SRC_CFG_RST    1'h1
// ==========================================================
// link byte values
`define SRC_ECHO1      8'hc1
`define SRC_ECHO2      8'hc2
`define SRC_ACK        8'h41
`define SRC_NAK        8'h4e
`define SRC_DUMMY      8'h00
`define SRC_POLY       8'h31
`define SRC_CRC_INIT   8'h00
`define SRC_OP_WRITE   2'h2
// ==========================================================
// timing
`define SRC_CLK_KHZ    50000
`define SRC_TMO_MS     360
`define SRC_TMO_CYC    (`SRC_TMO_MS * `SRC_CLK_KHZ + 1)
`define SRC_GAP_CYC    400
`define SRC_HALF_CYC   4
`define SRC_NAK_MAX    255
`endif

/* File: inc/src_pkg.sv */
// src_pkg: types of the spi register command host controller.
// assumes src_cfg.svh supplies every number.
package src_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_GAP,
      ST_SHIFT,
      ST_RECOVER
   } src_state_type;
   typedef enum logic [2:0] {
      PH_HDR1,
      PH_HDR2,
      PH_WDATA,
      PH_WCRC,
      PH_SYNC,
      PH_RDATA,
      PH_RCRC
   } src_phase_type;
endpackage

/* File: verilog/src_host.sv */
// src_host: spi master that runs register commands on the metering
// front-end; software drives it through a small register port.
// assumes mode 0 spi, one slave, miso asynchronous to core_clk_i.
`timescale 1ns/1ps
`include "src_cfg.svh"

module src_host #(
   parameter int HALF_CYC = `SRC_HALF_CYC,
   parameter int GAP_CYC  = `SRC_GAP_CYC,
   parameter int NAK_MAX  = `SRC_NAK_MAX,
   parameter int TMO_CYC  = `SRC_TMO_CYC
) (
   input  wire logic        core_clk_i, // 50 MHz clock
   input  wire logic        rst_b_i,    // sync reset, low
   input  wire logic [7:0]  addr_i,     // register byte address
   input  wire logic [31:0] wdata_i,    // register write data
   input  wire logic        wr_i,       // write strobe
   input  wire logic        rd_i,       // read strobe
   output logic      [31:0] rdata_o,    // read data, next cycle
   output logic             sclk_o,     // spi clock
   output logic             mosi_o,     // spi data out
   output logic             ssel_b_o,   // spi select, low
   input  wire logic        miso_i      // spi data in
);
   // ==========================================================
   // helpers
   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (r[7] ^ d[i]) begin
            r = {r[6:0], 1'b0} ^ `SRC_POLY;
         end else begin
            r = {r[6:0], 1'b0};
         end
      end
      return r;
   endfunction

   function automatic logic last_idx(input logic [3:0] idx,
                                     input logic [1:0] len);
      return idx == (4'((1 << len)) - 4'h1);
   endfunction

   // ==========================================================
   // miso synchroniser
   logic miso_m;
   logic miso_s;
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         miso_m <= 1'b0;
         miso_s <= 1'b0;
      end else begin
         miso_m <= miso_i;
         miso_s <= miso_m;
      end
   end

   // ==========================================================
   // software registers
   logic [15:0] cmd;
   logic [63:0] wdat;
   logic        crc_en;
   logic        f_done;
   logic        f_crc;
   logic        f_echo;
   logic        f_sync;
   logic [31:0] elap;
   logic        go;
   logic [15:0] next_cmd;
   logic [63:0] next_wdat;
   logic        next_crc_en;
   logic        next_f_done;
   logic        next_f_crc;
   logic        next_f_echo;
   logic        next_f_sync;
   logic [31:0] next_elap;
   logic        next_go;
   logic [31:0] next_rdata;
   // engine state
   src_pkg::src_state_type st;
   src_pkg::src_state_type next_st;
   src_pkg::src_phase_type ph;
   src_pkg::src_phase_type next_ph;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [2:0]  bitn;
   logic [2:0]  next_bitn;
   logic [7:0]  tx;
   logic [7:0]  next_tx;
   logic [7:0]  rx;
   logic [7:0]  next_rx;
   logic [7:0]  crc;
   logic [7:0]  next_crc;
   logic [3:0]  idx;
   logic [3:0]  next_idx;
   logic [7:0]  naks;
   logic [7:0]  next_naks;
   logic [63:0] rdat;
   logic [63:0] next_rdat;
   logic        next_sclk;
   logic        next_mosi;
   logic        next_ssel_b;
   logic        e_done;
   logic        e_crc;
   logic        e_echo;
   logic        e_sync;
   logic        busy;

   assign busy = (st != src_pkg::ST_IDLE) || go;

   always_comb begin
      next_cmd    = cmd;
      next_wdat   = wdat;
      next_crc_en = crc_en;
      next_go     = 1'b0;
      // hardware sets win over a software clear in the same cycle
      next_f_done = f_done | e_done;
      next_f_crc  = f_crc | e_crc;
      next_f_echo = f_echo | e_echo;
      next_f_sync = f_sync | e_sync;
      next_elap   = elap + 32'h1;
      next_rdata  = 32'h0;
      if (wr_i) begin
         case (addr_i)
            `SRC_OFS_CMD: begin
               // refused while busy, so one command at a time
               if (!busy && !wdata_i[`SRC_CMD_OP_LO]) begin
                  next_cmd = wdata_i[15:0];
                  next_go  = wdata_i[`SRC_CMD_GO];
               end
            end
            `SRC_OFS_CFG: next_crc_en = wdata_i[0];
            `SRC_OFS_WDLO: if (!busy) next_wdat[31:0] = wdata_i;
            `SRC_OFS_WDHI: if (!busy) next_wdat[63:32] = wdata_i;
            `SRC_OFS_STAT: begin
               if (wdata_i[`SRC_ST_DONE]) next_f_done = e_done;
               if (wdata_i[`SRC_ST_CRC]) next_f_crc = e_crc;
               if (wdata_i[`SRC_ST_ECHO]) next_f_echo = e_echo;
               if (wdata_i[`SRC_ST_SYNC]) next_f_sync = e_sync;
            end
            // restart the window timer on any software write to SRC_OFS_ELAP
            `SRC_OFS_ELAP: next_elap = 32'h0;
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            `SRC_OFS_CMD:  next_rdata = {16'h0, cmd};
            `SRC_OFS_CFG:  next_rdata = {31'h0, crc_en};
            `SRC_OFS_WDLO: next_rdata = wdat[31:0];
            `SRC_OFS_WDHI: next_rdata = wdat[63:32];
            `SRC_OFS_RDLO: next_rdata = rdat[31:0];
            `SRC_OFS_RDHI: next_rdata = rdat[63:32];
            `SRC_OFS_STAT: next_rdata = {27'h0, f_sync, f_echo,
                                         f_crc, f_done, busy};
            `SRC_OFS_ELAP: next_rdata = elap;
            default:       next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         cmd     <= 16'h0;
         wdat    <= 64'h0;
         crc_en  <= `SRC_CFG_RST; // crc on by default
         f_done  <= 1'b0;
         f_crc   <= 1'b0;
         f_echo  <= 1'b0;
         f_sync  <= 1'b0;
         elap    <= 32'h0;
         go      <= 1'b0;
         rdata_o <= 32'h0;
      end else begin
         cmd     <= next_cmd;
         wdat    <= next_wdat;
         crc_en  <= next_crc_en;
         f_done  <= next_f_done;
         f_crc   <= next_f_crc;
         f_echo  <= next_f_echo;
         f_sync  <= next_f_sync;
         elap    <= next_elap;
         go      <= next_go;
         rdata_o <= next_rdata;
      end
   end

   // ==========================================================
   // link engine
   logic       is_wr;
   logic [1:0] len;
   logic [7:0] c_up;
   assign is_wr = cmd[`SRC_CMD_OP_HI:`SRC_CMD_OP_LO] == `SRC_OP_WRITE;
   assign len   = cmd[`SRC_CMD_LEN_HI:`SRC_CMD_LEN_LO];
   assign c_up  = crc8(crc, tx);

   always_comb begin
      next_st     = st;
      next_ph     = ph;
      next_cnt    = cnt;
      next_bitn   = bitn;
      next_tx     = tx;
      next_rx     = rx;
      next_crc    = crc;
      next_idx    = idx;
      next_naks   = naks;
      next_rdat   = rdat;
      next_sclk   = sclk_o;
      next_ssel_b = ssel_b_o;
      e_done      = 1'b0;
      e_crc       = 1'b0;
      e_echo      = 1'b0;
      e_sync      = 1'b0;
      case (st)
         src_pkg::ST_IDLE: begin
            if (go) begin
               next_st     = src_pkg::ST_GAP;
               next_ph     = src_pkg::PH_HDR1;
               next_tx     = cmd[15:8];
               next_crc    = `SRC_CRC_INIT;
               next_idx    = 4'h0;
               next_naks   = 8'h0;
               next_cnt    = 32'h0;
               next_ssel_b = 1'b0;
            end
         end
         src_pkg::ST_GAP: begin
            next_cnt = cnt + 32'h1;
            if (cnt >= 32'(GAP_CYC - 1)) begin
               next_st   = src_pkg::ST_SHIFT;
               next_cnt  = 32'h0;
               next_bitn = 3'h0;
            end
         end
         src_pkg::ST_SHIFT: begin
            next_cnt = cnt + 32'h1;
            if (cnt >= 32'(HALF_CYC - 1)) begin
               next_cnt = 32'h0;
               if (!sclk_o) begin
                  next_sclk = 1'b1;
                  next_rx   = {rx[6:0], miso_s};
               end else begin
                  next_sclk = 1'b0;
                  next_bitn = bitn + 3'h1;
                  if (bitn == 3'h7) begin
                     next_st = src_pkg::ST_GAP;
                     next_tx = `SRC_DUMMY;
                     case (ph)
                        src_pkg::PH_HDR1: begin
                           if (rx != `SRC_ECHO1) e_echo = 1'b1;
                           next_crc = c_up;
                           next_ph  = src_pkg::PH_HDR2;
                           next_tx  = cmd[7:0];
                        end
                        src_pkg::PH_HDR2: begin
                           if (rx != `SRC_ECHO2) e_echo = 1'b1;
                           next_crc = c_up;
                           if (is_wr) begin
                              next_ph = src_pkg::PH_WDATA;
                              next_tx = wdat[7:0];
                           end else begin
                              next_ph = src_pkg::PH_SYNC;
                           end
                        end
                        src_pkg::PH_WDATA: begin
                           if (rx != `SRC_ACK) e_echo = 1'b1;
                           next_crc = c_up;
                           next_idx = idx + 4'h1;
                           next_tx  = wdat[8*next_idx +: 8]; // lsb first
                           if (last_idx(idx, len)) begin
                              if (crc_en) begin
                                 next_ph = src_pkg::PH_WCRC;
                                 next_tx = c_up;
                              end else begin
                                 next_ph = src_pkg::PH_SYNC;
                                 next_tx = `SRC_DUMMY;
                              end
                           end
                        end
                        src_pkg::PH_WCRC: begin
                           if (rx != `SRC_ACK) e_echo = 1'b1;
                           next_ph = src_pkg::PH_SYNC;
                        end
                        src_pkg::PH_SYNC: begin
                           // a stream of up to NAK_MAX naks is normal; anything else is lost
                           // sync and only the slave timeout clears it
                           if (rx == `SRC_ACK) begin
                              next_idx = 4'h0;
                              if (is_wr) begin
                                 next_st     = src_pkg::ST_IDLE;
                                 next_ssel_b = 1'b1;
                                 e_done      = 1'b1;
                              end else begin
                                 next_ph = src_pkg::PH_RDATA;
                              end
                           end else if (rx == `SRC_NAK &&
                                        naks < 8'(NAK_MAX)) begin
                              next_naks = naks + 8'h1;
                           end else begin
                              next_st     = src_pkg::ST_RECOVER;
                              next_ssel_b = 1'b1;
                              next_cnt    = 32'h0;
                              e_sync      = 1'b1;
                           end
                        end
                        src_pkg::PH_RDATA: begin
                           next_rdat[8*idx +: 8] = rx;
                           next_crc = crc8(crc, rx);
                           next_idx = idx + 4'h1;
                           if (last_idx(idx, len)) begin
                              if (crc_en) begin
                                 next_ph = src_pkg::PH_RCRC;
                              end else begin
                                 next_st     = src_pkg::ST_IDLE;
                                 next_ssel_b = 1'b1;
                                 e_done      = 1'b1;
                              end
                           end
                        end
                        src_pkg::PH_RCRC: begin
                           if (rx != crc) e_crc = 1'b1;
                           next_st     = src_pkg::ST_IDLE;
                           next_ssel_b = 1'b1;
                           e_done      = 1'b1;
                        end
                        default: next_st = src_pkg::ST_IDLE;
                     endcase
                  end
               end
            end
         end
         src_pkg::ST_RECOVER: begin
            // outlast the slave timeout before a fresh header
            next_cnt = cnt + 32'h1;
            if (cnt >= 32'(TMO_CYC - 1)) begin
               next_st = src_pkg::ST_IDLE;
            end
         end
         default: next_st = src_pkg::ST_IDLE;
      endcase
      next_mosi = next_tx[3'h7 - next_bitn];
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         st       <= src_pkg::ST_IDLE;
         ph       <= src_pkg::PH_HDR1;
         cnt      <= 32'h0;
         bitn     <= 3'h0;
         tx       <= 8'h0;
         rx       <= 8'h0;
         crc      <= 8'h0;
         idx      <= 4'h0;
         naks     <= 8'h0;
         rdat     <= 64'h0;
         sclk_o   <= 1'b0;
         mosi_o   <= 1'b0;
         ssel_b_o <= 1'b1;
      end else begin
         st       <= next_st;
         ph       <= next_ph;
         cnt      <= next_cnt;
         bitn     <= next_bitn;
         tx       <= next_tx;
         rx       <= next_rx;
         crc      <= next_crc;
         idx      <= next_idx;
         naks     <= next_naks;
         rdat     <= next_rdat;
         sclk_o   <= next_sclk;
         mosi_o   <= next_mosi;
         ssel_b_o <= next_ssel_b;
      end
   end
endmodule // src_host

/* File: verif/src_host_monitor.sv */
// src_host_monitor: link timing checks for the spi register command host.
// assumes it is bound to src_host and sees only that module's ports.
`timescale 1ns/1ps
`include "src_cfg.svh"

module src_host_monitor #(
   parameter int HALF_CYC = 4,
   parameter int GAP_CYC  = 400
) (
   input wire logic        core_clk_i, // clock
   input wire logic        rst_b_i,    // sync reset, low
   input wire logic [7:0]  addr_i,     // register address
   input wire logic [31:0] wdata_i,    // write data
   input wire logic        wr_i,       // write strobe
   input wire logic        rd_i,       // read strobe
   input wire logic [31:0] rdata_o,    // read data
   input wire logic        sclk_o,     // spi clock
   input wire logic        mosi_o,     // spi data out
   input wire logic        ssel_b_o,   // spi select, low
   input wire logic        miso_i      // spi data in
);
   // ==========================================================
   // helper counters
   logic        sclk_q, next_sclk_q;
   logic [2:0]  bits, next_bits;
   logic [19:0] hi_cnt, next_hi, lo_cnt, next_lo;
   logic [7:0]  since_go, next_go;

   always_comb begin
      next_sclk_q = sclk_o;
      next_bits   = ssel_b_o ? 3'h0 : bits + {2'h0, sclk_o & ~sclk_q};
      next_hi     = sclk_o ? hi_cnt + 20'h1 : 20'h0;
      next_lo     = sclk_o ? 20'h0 : lo_cnt + 20'h1;
      next_go     = (since_go == 8'hff) ? since_go : since_go + 8'h1;
      if (wr_i && addr_i == `SRC_OFS_CMD && wdata_i[31]) begin
         next_go = 8'h0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         sclk_q   <= 1'b0;
         bits     <= 3'h0;
         hi_cnt   <= 20'h0;
         lo_cnt   <= 20'h0;
         since_go <= 8'hff;
      end else begin
         sclk_q   <= next_sclk_q;
         bits     <= next_bits;
         hi_cnt   <= next_hi;
         lo_cnt   <= next_lo;
         since_go <= next_go;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   chk_clk_idle_low: assert property (ssel_b_o |-> !sclk_o)
      else $error("spi clock active while deselected");
   chk_high_half: assert property ($fell(sclk_o) |-> hi_cnt == HALF_CYC)
      else $error("spi clock high phase of wrong length");
   chk_low_half: assert property (
      $rose(sclk_o) && bits != 3'h0 |-> lo_cnt == HALF_CYC)
      else $error("spi clock low phase of wrong length");
   chk_byte_gap: assert property (
      $rose(sclk_o) && bits == 3'h0 |-> lo_cnt >= GAP_CYC)
      else $error("byte started without the required gap");
   chk_mosi_steady: assert property (sclk_o |-> $stable(mosi_o))
      else $error("data out changed while spi clock high");
   chk_byte_release: assert property (
      $rose(ssel_b_o) |-> bits == 3'h0 && !sclk_o)
      else $error("select released inside a byte");
   chk_start_after_go: assert property ($fell(ssel_b_o) |-> since_go <= 8'h4)
      else $error("select fell without a recent command");
   chk_reserved_op: assert property (
      wr_i && addr_i == `SRC_OFS_CMD && wdata_i[31] && wdata_i[14] && since_go == 8'hff
      |=> ssel_b_o [*6])
      else $error("reserved opcode started a transfer");
endmodule // src_host_monitor

bind src_host src_host_monitor #(
   .HALF_CYC(HALF_CYC),
   .GAP_CYC (GAP_CYC)
) mon (
   .core_clk_i(core_clk_i),
   .rst_b_i   (rst_b_i),
   .addr_i    (addr_i),
   .wdata_i   (wdata_i),
   .wr_i      (wr_i),
   .rd_i      (rd_i),
   .rdata_o   (rdata_o),
   .sclk_o    (sclk_o),
   .mosi_o    (mosi_o),
   .ssel_b_o  (ssel_b_o),
   .miso_i    (miso_i)
);

/* File: verif/src_slave_model.sv */
// src_slave_model: behavioural metering front-end on the far end of the link.
// assumes mode 0 and a host that releases select only between bytes.
`timescale 1ns/1ps

module src_slave_model (
   input  wire logic       sclk_i,    // spi clock from host
   input  wire logic       mosi_i,    // host data
   input  wire logic       ssel_b_i,  // select, low
   input  wire logic       crc_on_i,  // device crc mode
   input  wire logic [7:0] nak_n_i,   // busy replies per sync phase
   input  wire logic       bad_crc_i, // flip bit 0 of the read crc
   output logic            miso_o     // device data
);
   // ==========================================================
   // state
   logic [7:0]  mem [0:4095];
   logic [7:0]  wbuf [0:7];
   logic [7:0]  tx, rx, hdr1, hdr2, crc, naks;
   logic [11:0] addr;
   logic [3:0]  nb, k;
   logic [2:0]  ph, cnt;
   logic        acked, crc_ok;

   // released line shows the inverse of its last bit, never a held value
   assign miso_o = ssel_b_i ? ~tx[7] : tx[7];

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h31 : {r[6:0], 1'b0};
      return r;
   endfunction

   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[7:0] ^ 8'ha5;
      end
      tx = 8'hc1;
      ph = 3'd0;
      cnt = 3'd0;
   end

   // ==========================================================
   // byte engine
   task automatic sync_reply();
      if (naks != 8'h0) begin
         tx = 8'h4e;
         naks = naks - 8'h1;
      end else begin
         tx = 8'h41;
         acked = 1'b1;
      end
   endtask

   task automatic commit();
      if (crc_ok) for (int i = 0; i < nb; i++) mem[addr + 12'(i)] = wbuf[i];
      naks = nak_n_i;
      acked = 1'b0;
      sync_reply();
      ph = 3'd4;
   endtask

   task automatic load_data();
      tx = mem[addr + {8'h0, k}];
      crc = crc8(crc, tx);
      k = k + 4'h1;
   endtask

   // a new select always starts at the header: stands in for the timeout
   always @(negedge ssel_b_i) begin
      ph = 3'd0;
      cnt = 3'd0;
      tx = 8'hc1;
   end

   always @(posedge sclk_i) if (!ssel_b_i) begin
      rx = {rx[6:0], mosi_i};
      cnt = cnt + 3'h1;
   end

   always @(negedge sclk_i) if (!ssel_b_i) begin
      if (cnt != 3'h0) tx = {tx[6:0], 1'b0};
      else case (ph)
         3'd0: begin
            hdr1 = rx;
            nb = 4'h1 << rx[5:4];
            crc = crc8(8'h0, rx);
            tx = 8'hc2;
            ph = 3'd1;
         end
         3'd1: begin
            hdr2 = rx;
            addr = {hdr1[3:0], rx};
            crc = crc8(crc, rx);
            k = 4'h0;
            if (hdr1[7:6] == 2'h2) begin
               tx = 8'h41;
               ph = 3'd2;
            end else begin
               naks = nak_n_i;
               acked = 1'b0;
               sync_reply();
               ph = 3'd5;
            end
         end
         3'd2: begin
            wbuf[k[2:0]] = rx;
            crc = crc8(crc, rx);
            k = k + 4'h1;
            crc_ok = 1'b1;
            if (k != nb) tx = 8'h41;
            else if (crc_on_i) begin
               tx = 8'h41;
               ph = 3'd3;
            end else commit();
         end
         3'd3: begin
            crc_ok = (rx == crc);
            commit();
         end
         3'd4, 3'd5: begin
            if (!acked) sync_reply();
            else if (ph == 3'd4) begin
               tx = 8'hc1;
               ph = 3'd0;
            end else begin
               k = 4'h0;
               load_data();
               ph = 3'd6;
            end
         end
         3'd6: begin
            if (k != nb) load_data();
            else if (crc_on_i) begin
               tx = crc ^ {7'h0, bad_crc_i};
               ph = 3'd7;
            end else begin
               tx = 8'hc1;
               ph = 3'd0;
            end
         end
         default: begin
            tx = 8'hc1;
            ph = 3'd0;
         end
      endcase
   end
endmodule // src_slave_model

/* File: verif/src_host_tb.sv */
// src_host_tb: self-checking bench for the spi register command host.
// assumes src_slave_model as far end and short sim values of the counts.
`timescale 1ns/1ps

module src_host_tb;
   localparam int NAK_MAX = 4;
   logic        core_clk_i = 1'b0;
   logic        rst_b_i    = 1'b0;
   logic [7:0]  addr_i     = 8'h00;
   logic [31:0] wdata_i    = 32'h0;
   logic        wr_i       = 1'b0;
   logic        rd_i       = 1'b0;
   logic [31:0] rdata_o, d, d2;
   logic        sclk_o, mosi_o, ssel_b_o, miso_i;
   logic        crc_on     = 1'b1;
   logic [7:0]  nak_n      = 8'h0;
   logic        bad_crc    = 1'b0;
   int          mismatches = 0;
   int          checks     = 0;
   int          cyc        = 0;

   always #10 core_clk_i = ~core_clk_i;

   src_host #(.HALF_CYC(4), .GAP_CYC(20), .NAK_MAX(NAK_MAX), .TMO_CYC(200)) DUT (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_o(sclk_o), .mosi_o(mosi_o),
      .ssel_b_o(ssel_b_o), .miso_i(miso_i));

   src_slave_model partner (
      .sclk_i(sclk_o), .mosi_i(mosi_o), .ssel_b_i(ssel_b_o), .crc_on_i(crc_on),
      .nak_n_i(nak_n), .bad_crc_i(bad_crc), .miso_o(miso_i));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // strobe drops before the closing edge so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(posedge core_clk_i);
      v = rdata_o;
   endtask

   task automatic wait_cmd(input logic [1:0] op, input logic [1:0] len,
                           input logic [11:0] a, input logic [31:0] st);
      int n;
      n = 0;
      d = 32'h1;
      repeat (2) @(posedge core_clk_i);
      while (d[0] !== 1'b0 && n < 4000) begin
         rd(8'h18, d);
         n++;
      end
      check(d, st);
      check(partner.hdr1, {op, len, a[11:8]});
      check(partner.hdr2, a[7:0]);
      wr(8'h18, 32'h1e);
   endtask

   task automatic xfer(input logic [1:0] op, input logic [1:0] len,
                       input logic [11:0] a, input logic [31:0] st);
      wr(8'h00, {16'h8000, op, len, a});
      wait_cmd(op, len, a, st);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd(8'h04, d);
      check(d, 32'h1);
      rd(8'h18, d);
      check(d, 32'h0);
      rd(8'h20, d);
      check(d, 32'h0);
      wr(8'h1c, 32'h0);
      rd(8'h1c, d);
      check(d, 32'h1);
   endtask

   task automatic t_traffic();
      logic [11:0] at [4] = '{12'h000, 12'h123, 12'h800, 12'hff8};
      logic [63:0] v, m;
      for (int c = 1; c >= 0; c--) begin
         wr(8'h04, 32'(c));
         crc_on <= c[0];
         for (int l = 0; l < 4; l++) begin
            v = 64'h0123_4567_89ab_cdef ^ {8{c[3:0], l[3:0]}};
            m = {64{1'b1}} >> (64 - (8 << l));
            nak_n <= 8'(l + 1);
            wr(8'h08, v[31:0]);
            wr(8'h0c, v[63:32]);
            xfer(2'h2, l[1:0], at[l], 32'h2);
            xfer(2'h0, l[1:0], at[l], 32'h2);
            rd(8'h10, d);
            rd(8'h14, d2);
            check({d2, d} & m, v & m);
         end
      end
   endtask

   task automatic t_bad_crc();
      wr(8'h04, 32'h1);
      crc_on <= 1'b1;
      bad_crc <= 1'b1;
      nak_n <= 8'h0;
      xfer(2'h0, 2'h1, 12'h3c0, 32'h6);
      bad_crc <= 1'b0;
      rd(8'h18, d);
      check(d, 32'h0);
   endtask

   task automatic t_sync_lost();
      nak_n <= 8'(NAK_MAX + 1);
      xfer(2'h0, 2'h0, 12'h010, 32'h10);
      nak_n <= 8'h2;
      xfer(2'h0, 2'h0, 12'h010, 32'h2);
      rd(8'h10, d);
      check(d[7:0], 8'hb5);
   endtask

   task automatic t_refuse();
      wr(8'h08, 32'h5a);
      wr(8'h00, 32'h8000_4055);
      repeat (8) @(posedge core_clk_i);
      check(ssel_b_o, 1'b1);
      wr(8'h00, 32'h8000_8055);
      wr(8'h08, 32'h77);
      wr(8'h00, 32'h8000_8066);
      wait_cmd(2'h2, 2'h0, 12'h055, 32'h2);
      xfer(2'h0, 2'h0, 12'h055, 32'h2);
      rd(8'h10, d);
      check(d[7:0], 8'h5a);
      rd(8'h00, d);
      check(d, 32'h55);
   endtask

   // ==========================================================
   // main sequence and hang guard
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         test_done();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      @(posedge core_clk_i);
      t_reset();
      t_traffic();
      t_bad_crc();
      t_sync_lost();
      t_refuse();
      test_done();
   end
endmodule // src_host_tb
